// ===== rtl/tcis_regs.svh
`ifndef TCIS_REGS_SVH
`define TCIS_REGS_SVH

// register map: enable register of channel n at 2n, status at 2n+1
`define TCIS_ADDR_W        4
`define TCIS_NUM_CH        6
`define TCIS_ENA_BASE      4'h0
`define TCIS_STS_BASE      4'h1
`define TCIS_DIR_ADDR      4'hc
`define TCIS_ENA_RESET     8'h40
`define TCIS_STS_RESET     8'hc0
`define TCIS_NOMAP_DATA    8'h00
// field positions shared by both registers
`define TCIS_BIT_A         0
`define TCIS_BIT_B         1
`define TCIS_BIT_C         2
`define TCIS_BIT_D         3
`define TCIS_BIT_OVF       4
`define TCIS_BIT_UNF       5
`define TCIS_BIT_FIXED     6
`define TCIS_BIT_TOP       7
// writable masks per channel kind
`define TCIS_ENA_MASK_FOUR 8'h9f
`define TCIS_ENA_MASK_TWO  8'hb3
`define TCIS_STS_MASK_FOUR 8'h1f
`define TCIS_STS_MASK_TWO  8'h33
`define TCIS_FOUR_CH_MAP   6'h09

`endif

// ===== rtl/tcis_pkg.sv
package tcis_pkg;

	// per-channel event strobes from the counter datapath
	typedef struct packed {
		logic match_a;
		logic match_b;
		logic match_c;
		logic match_d;
		logic overflow;
		logic underflow;
	} tcis_event_s;

	// per-channel transfer-controller clear requests
	typedef struct packed {
		logic clr_a;
		logic clr_b;
		logic clr_c;
		logic clr_d;
		logic clr_a_dma;
	} tcis_xfer_clr_s;

	// per-channel request outputs
	typedef struct packed {
		logic match_a_irq;
		logic match_b_irq;
		logic match_c_irq;
		logic match_d_irq;
		logic overflow_irq;
		logic underflow_irq;
		logic adc_trigger;
	} tcis_req_s;

	typedef logic [7:0] tcis_byte_t;

	typedef struct packed {
		tcis_byte_t [5:0] irq_enable_reg;
		tcis_byte_t [5:0] event_status_reg;
		logic [5:0]       armed;
		tcis_req_s [5:0]  req;
		tcis_byte_t       rdata;
	} tcis_state_s;

endpackage

// ===== rtl/tcis_top.sv
// Summary of operation
// R1 - enable register resets to 0x40 on reset and hardware standby
// R2 - status register resets to 0xc0 on reset and hardware standby
// R3 - enable bit 7 lets every A match or capture request an A/D start
// R4 - bit 6 of enable and status reads one and ignores writes
// R5 - enable bit 5 gates underflow request; zero on channels 0 and 3
// R6 - enable bit 4 gates overflow request on every channel
// R7 - enable bit 3 gates D request; zero elsewhere than channels 0, 3
// R8 - enable bit 2 gates C request; zero elsewhere than channels 0, 3
// R9 - enable bit 1 gates B request on all six channels
// R10 - enable bit 0 gates A request on all six channels
// R11 - flags clear only by zero written after reading them as one; code arms on any flag of the register read as one
// R12 - status bit 7 shows count direction on up/down channels, resets one
// R13 - status bit 7 reads one on channels 0 and 3
// R14 - underflow flag set on downward wrap; zero on channels 0 and 3
// R15 - overflow flag set on upward wrap on every channel
// R16 - D flag set by D match or capture on channels 0 and 3
// R17 - D flag cleared by transfer controller activation
// R18 - A, B, C flags set by match or capture; C on channels 0, 3 only
// R19 - A, B, C cleared by transfer activation; A also by DMA activation
// R20 - each interrupt request is flag AND enable, held while both are one
`include "tcis_regs.svh"

module tcis_top (
	input  wire logic                          CLK_SYS,
	input  wire logic                          RESET,
	input  wire logic                          CLK_EN,
	input  wire logic                          HW_STANDBY,
	input  wire logic [`TCIS_ADDR_W-1:0]       ADDR,
	input  wire logic [7:0]                    WDATA,
	input  wire logic                          WR_STB,
	input  wire logic                          RD_STB,
	output logic [7:0]                         RDATA,
	input  wire tcis_pkg::tcis_event_s [5:0]   EVENTS,
	input  wire tcis_pkg::tcis_xfer_clr_s [5:0] XFER_CLR,
	input  wire logic [5:0]                    COUNT_UP,
	output tcis_pkg::tcis_req_s [5:0]          REQ
);

	tcis_pkg::tcis_state_s state;
	tcis_pkg::tcis_state_s next_state;

	// standby is asynchronous to bus activity, so resynchronise it
	logic standby_meta;
	logic standby_sync;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			standby_meta <= 1'b0;
			standby_sync <= 1'b0;
		end else if (CLK_EN) begin
			standby_meta <= HW_STANDBY;
			standby_sync <= standby_meta;
		end
	end

	function automatic logic is_four(input int ch);
		logic [5:0] map;
		map = `TCIS_FOUR_CH_MAP;
		return map[ch];
	endfunction

	always_comb begin
		logic [7:0] ena;
		logic [7:0] sts;
		logic [7:0] ena_mask;
		logic [7:0] sts_mask;
		logic [7:0] set_v;
		logic [7:0] clr_v;
		logic       wr_ena;
		logic       wr_sts;
		logic       rd_sts;
		ena = 8'h00;
		sts = 8'h00;
		ena_mask = 8'h00;
		sts_mask = 8'h00;
		set_v = 8'h00;
		clr_v = 8'h00;
		wr_ena = 1'b0;
		wr_sts = 1'b0;
		rd_sts = 1'b0;
		next_state = state;
		next_state.rdata = `TCIS_NOMAP_DATA;

		if (RD_STB) begin
			if (ADDR == `TCIS_DIR_ADDR)
				next_state.rdata = {2'h0, COUNT_UP};
			for (int ch = 0; ch < `TCIS_NUM_CH; ch++) begin
				if (ADDR == 4'((ch << 1) + `TCIS_ENA_BASE))
					next_state.rdata = state.irq_enable_reg[ch];
				if (ADDR == 4'((ch << 1) + `TCIS_STS_BASE))
					next_state.rdata = state.event_status_reg[ch];
			end
		end

		for (int ch = 0; ch < `TCIS_NUM_CH; ch++) begin
			ena = state.irq_enable_reg[ch];
			sts = state.event_status_reg[ch];
			ena_mask = is_four(ch) ? `TCIS_ENA_MASK_FOUR : `TCIS_ENA_MASK_TWO;
			sts_mask = is_four(ch) ? `TCIS_STS_MASK_FOUR : `TCIS_STS_MASK_TWO;
			wr_ena = WR_STB && ADDR == 4'((ch << 1) + `TCIS_ENA_BASE);
			wr_sts = WR_STB && ADDR == 4'((ch << 1) + `TCIS_STS_BASE);
			rd_sts = RD_STB && ADDR == 4'((ch << 1) + `TCIS_STS_BASE);

			// bits outside the mask (fixed one, reserved zero) never move
			if (wr_ena)
				ena = (ena & ~ena_mask) | (WDATA & ena_mask); // see R4, R5
			ena[`TCIS_BIT_FIXED] = 1'b1; // see R4

			set_v[`TCIS_BIT_A] = EVENTS[ch].match_a; // see R18
			set_v[`TCIS_BIT_B] = EVENTS[ch].match_b; // see R18
			set_v[`TCIS_BIT_C] = EVENTS[ch].match_c; // see R18
			set_v[`TCIS_BIT_D] = EVENTS[ch].match_d; // see R16
			set_v[`TCIS_BIT_OVF] = EVENTS[ch].overflow; // see R15
			set_v[`TCIS_BIT_UNF] = EVENTS[ch].underflow; // see R14
			set_v[`TCIS_BIT_FIXED] = 1'b0;
			set_v[`TCIS_BIT_TOP] = 1'b0;

			clr_v = 8'h00;
			clr_v[`TCIS_BIT_A] = XFER_CLR[ch].clr_a
				|| XFER_CLR[ch].clr_a_dma; // see R19
			clr_v[`TCIS_BIT_B] = XFER_CLR[ch].clr_b; // see R19
			clr_v[`TCIS_BIT_C] = XFER_CLR[ch].clr_c; // see R19
			clr_v[`TCIS_BIT_D] = XFER_CLR[ch].clr_d; // see R17
			// zero written to a flag only counts after a read saw any flag of the register as one
			if (wr_sts)
				clr_v = clr_v | (state.armed[ch]
					? (~WDATA & sts) : 8'h00); // see R11
			// a written one never sets; a new event beats any clear
			sts = ((sts & ~clr_v) | set_v) & sts_mask; // see R11
			sts[`TCIS_BIT_FIXED] = 1'b1; // see R4
			sts[`TCIS_BIT_TOP] = is_four(ch) ? 1'b1 : COUNT_UP[ch]; // see R12, R13

			// arm when any flag is read as one; a write to this status register disarms
			if (rd_sts)
				next_state.armed[ch] = |(state.event_status_reg[ch]
					& sts_mask);
			else if (wr_sts)
				next_state.armed[ch] = 1'b0;

			next_state.irq_enable_reg[ch] = ena;
			next_state.event_status_reg[ch] = sts;

			next_state.req[ch].match_a_irq = sts[`TCIS_BIT_A]
				&& ena[`TCIS_BIT_A]; // see R10, R20
			next_state.req[ch].match_b_irq = sts[`TCIS_BIT_B]
				&& ena[`TCIS_BIT_B]; // see R9, R20
			next_state.req[ch].match_c_irq = sts[`TCIS_BIT_C]
				&& ena[`TCIS_BIT_C]; // see R8, R20
			next_state.req[ch].match_d_irq = sts[`TCIS_BIT_D]
				&& ena[`TCIS_BIT_D]; // see R7, R20
			next_state.req[ch].overflow_irq = sts[`TCIS_BIT_OVF]
				&& ena[`TCIS_BIT_OVF]; // see R6, R20
			next_state.req[ch].underflow_irq = sts[`TCIS_BIT_UNF]
				&& ena[`TCIS_BIT_UNF]; // see R5, R20
			next_state.req[ch].adc_trigger = EVENTS[ch].match_a
				&& state.irq_enable_reg[ch][`TCIS_BIT_TOP]; // see R3
		end

		if (standby_sync) begin
			for (int ch = 0; ch < `TCIS_NUM_CH; ch++) begin
				next_state.irq_enable_reg[ch] = `TCIS_ENA_RESET; // see R1
				next_state.event_status_reg[ch] = `TCIS_STS_RESET; // see R2
				next_state.armed[ch] = 1'b0;
				next_state.req[ch] = '0;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			for (int ch = 0; ch < `TCIS_NUM_CH; ch++) begin
				state.irq_enable_reg[ch] <= `TCIS_ENA_RESET; // see R1
				state.event_status_reg[ch] <= `TCIS_STS_RESET; // see R2
				state.req[ch] <= '0;
			end
			state.armed <= '0;
			state.rdata <= `TCIS_NOMAP_DATA;
		end else if (CLK_EN) begin
			state <= next_state;
		end
	end

	assign RDATA = state.rdata;
	assign REQ = state.req;

endmodule // tcis_top

// ===== bench/tcis_props.sv
module tcis_props (
	input wire logic                            CLK_SYS,
	input wire logic                            RESET,
	input wire logic                            HW_STANDBY,
	input wire logic                            WR_STB,
	input wire logic                            RD_STB,
	input wire logic [7:0]                      RDATA,
	input wire tcis_pkg::tcis_event_s [5:0]     EVENTS,
	input wire tcis_pkg::tcis_xfer_clr_s [5:0]  XFER_CLR,
	input wire tcis_pkg::tcis_req_s [5:0]       REQ
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	// standby reinit lags its pin by the two sync flops; only the cycles with the pin high are masked
	default disable iff (RESET || HW_STANDBY);
	a_rdata_idle: assert property (!RD_STB |=> RDATA == 8'h00)
		else $error("read data not zero outside a read");
	a_adc_cause: assert property (
		REQ[0].adc_trigger |-> $past(EVENTS[0].match_a))
		else $error("adc trigger without an A event");
	a_c_gone: assert property (!REQ[1].match_c_irq)
		else $error("C request on a two-register channel");
	a_d_gone: assert property (!REQ[2].match_d_irq)
		else $error("D request on a two-register channel");
	a_unf_gone: assert property (!REQ[3].underflow_irq)
		else $error("underflow request on a four-register channel");
	a_rise_cause: assert property (
		$rose(REQ[1].overflow_irq) |->
		$past(EVENTS[1].overflow) || $past(WR_STB))
		else $error("overflow request rose without a cause");
	a_fall_cause: assert property (
		$fell(REQ[0].match_a_irq) |-> $past(WR_STB) ||
		$past(XFER_CLR[0].clr_a) || $past(XFER_CLR[0].clr_a_dma))
		else $error("A request fell without a cause");
	a_xfer_clear_d: assert property (
		XFER_CLR[0].clr_d && !EVENTS[0].match_d |=> !REQ[0].match_d_irq)
		else $error("D request kept after transfer clear");
	a_dma_clear_a: assert property (
		XFER_CLR[3].clr_a_dma && !EVENTS[3].match_a |=> !REQ[3].match_a_irq)
		else $error("A request kept after dma clear");
	a_hold_req: assert property (
		REQ[3].match_b_irq && !WR_STB && !XFER_CLR[3].clr_b |=>
		REQ[3].match_b_irq)
		else $error("B request dropped by itself");
	cover property (REQ[0].adc_trigger);
	cover property ($fell(REQ[0].match_a_irq));
	cover property ($rose(REQ[1].overflow_irq));
endmodule // tcis_props

// ===== bench/tcis_top_bench.sv
module tcis_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, reset = 1, hw_standby = 0, wr_stb = 0, rd_stb = 0;
	logic clk_en = 1;
	logic [3:0] addr = '0, ea;
	logic [7:0] wdata = '0, rdata;
	logic [5:0] count_up = '1;
	tcis_pkg::tcis_event_s [5:0] events = '0;
	tcis_pkg::tcis_xfer_clr_s [5:0] xfer_clr = '0;
	tcis_pkg::tcis_req_s [5:0] req;
	int error_cnt = 0, check_count = 0, cycles = 0;
	bit f;
	tcis_top tcis_top_i (.CLK_SYS(clk_sys), .RESET(reset), .CLK_EN(clk_en),
		.HW_STANDBY(hw_standby), .ADDR(addr), .WDATA(wdata),
		.WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
		.EVENTS(events), .XFER_CLR(xfer_clr), .COUNT_UP(count_up),
		.REQ(req));
	task automatic tally_and_finish();
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk_sys);
		wr_stb <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr_stb <= 1'h0;
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e);
		@(posedge clk_sys);
		rd_stb <= 1'h1;
		addr <= a;
		@(posedge clk_sys);
		rd_stb <= 1'h0;
		#1 chk("rdata", e, rdata);
	endtask
	// event and transfer-clear pulses last exactly one cycle
	task automatic pulse(int ch, logic [5:0] e, logic [4:0] c);
		@(posedge clk_sys);
		events[ch] <= e;
		xfer_clr[ch] <= c;
		@(posedge clk_sys);
		events[ch] <= '0;
		xfer_clr[ch] <= '0;
	endtask
	task automatic rq(int ch, logic [6:0] e);
		#1 chk("req", {1'h0, e}, {1'h0, req[ch]});
	endtask
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'h0;
		for (int ch = 0; ch < 6; ch++) begin
			ea = 4'(2 * ch);
			f = ch == 0 || ch == 3;
			rd(ea, 8'h40);
			rd(ea + 4'h1, 8'hc0);
			wr(ea, 8'hff);
			rd(ea, f ? 8'hdf : 8'hf3);
			wr(ea + 4'h1, 8'hff);
			rd(ea + 4'h1, 8'hc0);
			pulse(ch, 6'h3f, 5'h00);
			rq(ch, f ? 7'h7d : 7'h67);
			// no read has armed the clear, so this write must be ignored
			wr(ea + 4'h1, 8'h00);
			rd(ea + 4'h1, f ? 8'hdf : 8'hf3);
			pulse(ch, 6'h00, 5'h1f);
			rq(ch, f ? 7'h04 : 7'h06);
			rd(ea + 4'h1, f ? 8'hd0 : 8'hf0);
			// zeros written to the overflow and underflow flags after the read must clear them
			wr(ea + 4'h1, 8'hcf);
			rq(ch, 7'h00);
		end
		wr(4'h0, 8'h01);
		pulse(0, 6'h20, 5'h00);
		rq(0, 7'h40);
		// a frozen clock enable must swallow the event
		@(posedge clk_sys);
		clk_en <= 1'h0;
		pulse(1, 6'h20, 5'h00);
		@(posedge clk_sys);
		clk_en <= 1'h1;
		rq(1, 7'h00);
		count_up <= 6'h3d;
		rd(4'h3, 8'h40);
		rd(4'hc, 8'h3d);
		rd(4'hd, 8'h00);
		@(posedge clk_sys);
		hw_standby <= 1'h1;
		repeat (5) @(posedge clk_sys);
		hw_standby <= 1'h0;
		repeat (4) @(posedge clk_sys);
		rd(4'h0, 8'h40);
		rd(4'h1, 8'hc0);
		tally_and_finish();
	end
endmodule // tcis_top_bench
bind tcis_top tcis_props tcis_props_i (.CLK_SYS(CLK_SYS), .RESET(RESET),
	.HW_STANDBY(HW_STANDBY), .WR_STB(WR_STB), .RD_STB(RD_STB),
	.RDATA(RDATA), .EVENTS(EVENTS), .XFER_CLR(XFER_CLR), .REQ(REQ));
